// [design/relocatable_vector_table.v]
// Relocatable interrupt vector address logic with source selection
//
// Summary of operation
// - Vector area is 256 bytes from base
// - Even base gives shorter interrupt sequence
// - Slots offset from base; breakpoint at +0
// - Pin three uses number 4, +16
// - Capture/compare 0 uses number 5, +20
// - Number 6 shared: compare 1, two-wire
// - Number 7 shared: base timer, line event
// - Slots 8 and 9 shared, serial/pin
// - Unit two collision uses number 10
// - Two-wire mode: start/stop raises number 10
// - DMA channels use numbers 11, 12
// - Key input 13, conversion 14
// - Unit two tx/rx 15, 16; ack events
// - Units zero, one use 17 to 20
// - First timers use numbers 21 to 25
// - Second timers use numbers 26 to 28
// - Pins zero to two use 29 to 31
// - Numbers 32 to 63 software only
// - Breakpoint and 32-63 ignore global enable
// - Entries four bytes, hold routine start
// - Accept: enable, request, level above current
`timescale 1ns/1ps
`include "vector_table_regs.vh"
module relocatable_vector_table (
    input  wire                    MCLK,
    input  wire                    RESETN,
    input  wire                    CE,
    input  wire [`VT_BASE_W-1:0]   VECTOR_BASE,
    input  wire                    CAUSE_WR,
    input  wire [7:0]              CAUSE_WDATA,
    input  wire                    CAUSE2_WR,
    input  wire [7:0]              CAUSE2_WDATA,
    input  wire                    TWO_WIRE_MODE,
    input  wire                    GLOBAL_EN,
    input  wire [`VT_LVL_W-1:0]    PROC_LEVEL,
    input  wire                    EXT_PIN_IRQ3_REQ,
    input  wire                    CC0_REQ,
    input  wire                    CC1_REQ,
    input  wire                    IIC_REQ,
    input  wire                    CCB_REQ,
    input  wire                    LINE_REQ,
    input  wire                    SP4_REQ,
    input  wire                    EXT_PIN_IRQ5_REQ,
    input  wire                    SP3_REQ,
    input  wire                    EXT_PIN_IRQ4_REQ,
    input  wire                    U2_COLL_REQ,
    input  wire                    U2_STSP_REQ,
    input  wire                    DMA0_REQ,
    input  wire                    DMA1_REQ,
    input  wire                    KEY_REQ,
    input  wire                    AD_REQ,
    input  wire                    U2_TX_REQ,
    input  wire                    U2_RX_REQ,
    input  wire                    U2_NACK_REQ,
    input  wire                    U2_ACK_REQ,
    input  wire [3:0]              UART01_REQ,
    input  wire [4:0]              TMR_A_REQ,
    input  wire [2:0]              TMR_B_REQ,
    input  wire [2:0]              INT012_REQ,
    input  wire [83:0]             SLOT_LEVELS,
    input  wire                    SW_REQ,
    input  wire [`VT_NUM_W-1:0]    SW_NUM,
    input  wire                    FETCH_DONE,
    output wire                    IRQ_PENDING,
    output reg                     VEC_VALID,
    output reg  [`VT_NUM_W-1:0]    VEC_NUM,
    output reg  [`VT_BASE_W-1:0]   VEC_ADDR,
    output reg  [`VT_LVL_W-1:0]    VEC_LEVEL,
    output reg                     VEC_MASKABLE,
    output reg  [4:0]              SEQ_CYCLES,
    output reg  [7:0]              CAUSE_SEL,
    output reg  [7:0]              CAUSE_SEL_TWO
);
    localparam ST_IDLE = 1'b0;
    localparam ST_HOLD = 1'b1;

    reg                   state_r;
    reg                   state_nxt;
    wire                  sel_slot6_bit;
    wire                  sel_slot7_bit;
    wire                  sel_slot8_bit;
    wire                  sel_slot9_bit;
    wire [27:0]           hw_req;
    wire [31:0]           slot_req;
    wire [95:0]           slot_lvl;
    reg                   hw_found;
    reg  [`VT_NUM_W-1:0]  hw_num;
    reg  [`VT_LVL_W-1:0]  hw_lvl;
    reg                   take_hw;
    reg                   take_sw;
    integer               i;

    // Cause-select registers, written by software
    always @(posedge MCLK) begin
        if (!RESETN) begin
            CAUSE_SEL     <= `VT_CAUSE_RST;
            CAUSE_SEL_TWO <= `VT_CAUSE2_RST;
        end else if (CE) begin
            if (CAUSE_WR)
                CAUSE_SEL <= CAUSE_WDATA;
            if (CAUSE2_WR)
                CAUSE_SEL_TWO <= CAUSE2_WDATA;
        end
    end

    assign sel_slot6_bit = CAUSE_SEL_TWO[`VT_SEL2_SLOT6_BIT];
    assign sel_slot7_bit = CAUSE_SEL_TWO[`VT_SEL2_SLOT7_BIT];
    assign sel_slot8_bit = CAUSE_SEL[`VT_SEL_SLOT7_BIT];
    assign sel_slot9_bit = CAUSE_SEL[`VT_SEL_SLOT6_BIT];

    // Request lines in number order, 4 through 31
    assign hw_req[0] = EXT_PIN_IRQ3_REQ;
    assign hw_req[1] = CC0_REQ;
    // Select bit low picks the capture/compare source
    assign hw_req[2] = sel_slot6_bit ? IIC_REQ : CC1_REQ;
    assign hw_req[3] = sel_slot7_bit ? LINE_REQ : CCB_REQ;
    // Select bit low picks the serial port, high the pin
    assign hw_req[4] = sel_slot8_bit ? EXT_PIN_IRQ5_REQ : SP4_REQ;
    assign hw_req[5] = sel_slot9_bit ? EXT_PIN_IRQ4_REQ : SP3_REQ;
    assign hw_req[6] = TWO_WIRE_MODE ? U2_STSP_REQ
                                     : U2_COLL_REQ;
    assign hw_req[7] = DMA0_REQ;
    assign hw_req[8] = DMA1_REQ;
    assign hw_req[9] = KEY_REQ;
    assign hw_req[10] = AD_REQ;
    assign hw_req[11] = TWO_WIRE_MODE ? U2_NACK_REQ : U2_TX_REQ;
    assign hw_req[12] = TWO_WIRE_MODE ? U2_ACK_REQ : U2_RX_REQ;
    assign hw_req[16:13] = UART01_REQ;
    assign hw_req[21:17] = TMR_A_REQ;
    assign hw_req[24:22] = TMR_B_REQ;
    assign hw_req[27:25] = INT012_REQ;

    vector_src_map u_map (
        .req_in  (hw_req),
        .lvl_in  (SLOT_LEVELS),
        .req_out (slot_req),
        .lvl_out (slot_lvl)
    );

    // Highest level wins; ties go to the lower number
    always @* begin
        hw_found = 1'b0;
        hw_num   = {`VT_NUM_W{1'b0}};
        hw_lvl   = {`VT_LVL_W{1'b0}};
        for (i = 4; i < 32; i = i + 1) begin
            if (slot_req[i] && (slot_lvl[i*3 +: 3] > PROC_LEVEL) &&
                (!hw_found || (slot_lvl[i*3 +: 3] > hw_lvl))) begin
                hw_found = 1'b1;
                hw_num   = i[`VT_NUM_W-1:0];
                hw_lvl   = slot_lvl[i*3 +: 3];
            end
        end
    end

    assign IRQ_PENDING = hw_found && GLOBAL_EN;

    // Software numbers are taken regardless of the global enable
    always @* begin
        take_sw   = 1'b0;
        take_hw   = 1'b0;
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (SW_REQ) begin
                    take_sw   = 1'b1;
                    state_nxt = ST_HOLD;
                end else if (IRQ_PENDING) begin
                    take_hw   = 1'b1;
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (FETCH_DONE)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge MCLK) begin
        if (!RESETN) begin
            state_r      <= ST_IDLE;
            VEC_VALID    <= 1'b0;
            VEC_NUM      <= {`VT_NUM_W{1'b0}};
            VEC_ADDR     <= {`VT_BASE_W{1'b0}};
            VEC_LEVEL    <= {`VT_LVL_W{1'b0}};
            VEC_MASKABLE <= 1'b0;
            SEQ_CYCLES   <= 5'h00;
        end else if (CE) begin
            state_r <= state_nxt;
            if (take_sw || take_hw) begin
                VEC_VALID <= 1'b1;
                VEC_NUM   <= take_sw ? SW_NUM : hw_num;
                // Four-byte slot, 64 slots fill the 256-byte area
                VEC_ADDR  <= VECTOR_BASE +
                    {{(`VT_BASE_W-8){1'b0}},
                     (take_sw ? SW_NUM : hw_num), 2'b00};
                VEC_LEVEL <= take_sw ? PROC_LEVEL : hw_lvl;
                // Breakpoint and 32-63 are never maskable; 1-31 by
                // software instruction reuse the peripheral slot
                VEC_MASKABLE <= take_hw;
                // Odd base splits each word fetch, costing cycles
                SEQ_CYCLES <= VECTOR_BASE[0] ? `VT_SEQ_ODD_CYC
                                             : `VT_SEQ_EVEN_CYC;
            end else if (state_r == ST_HOLD && FETCH_DONE) begin
                VEC_VALID <= 1'b0;
            end
        end
    end
endmodule // relocatable_vector_table

// [design/vector_table_regs.vh]
// Constants for the relocatable vector address logic
`ifndef VECTOR_TABLE_REGS_VH
`define VECTOR_TABLE_REGS_VH
`define VT_AREA_BYTES      9'h100
`define VT_SLOT_BYTES      3'h4
`define VT_NUM_W           6
`define VT_BASE_W          20
`define VT_LVL_W           3
`define VT_NUM_BRK         6'h00
`define VT_NUM_EXT_PIN_IRQ3        6'h04
`define VT_NUM_CC0         6'h05
`define VT_NUM_CC1_IIC     6'h06
`define VT_NUM_CCB_SCL     6'h07
`define VT_NUM_SP4_EXT_PIN_IRQ5    6'h08
`define VT_NUM_SP3_EXT_PIN_IRQ4    6'h09
`define VT_NUM_U2BC        6'h0A
`define VT_NUM_DMA0        6'h0B
`define VT_NUM_DMA1        6'h0C
`define VT_NUM_KEY         6'h0D
`define VT_NUM_AD          6'h0E
`define VT_NUM_U2TX        6'h0F
`define VT_NUM_U2RX        6'h10
`define VT_NUM_U0TX        6'h11
`define VT_NUM_U0RX        6'h12
`define VT_NUM_U1TX        6'h13
`define VT_NUM_U1RX        6'h14
`define VT_NUM_TA0         6'h15
`define VT_NUM_TB0         6'h1A
`define VT_NUM_EXT_PIN_IRQ0        6'h1D
`define VT_NUM_SW_FIRST    6'h20
`define VT_NUM_HW_LAST     6'h1F
`define VT_SEL_SLOT6_BIT   6
`define VT_SEL_SLOT7_BIT   7
`define VT_SEL2_SLOT6_BIT  6
`define VT_SEL2_SLOT7_BIT  7
`define VT_SEQ_EVEN_CYC    5'h12
`define VT_SEQ_ODD_CYC     5'h14
`define VT_CAUSE_RST       8'h00
`define VT_CAUSE2_RST      8'h00
`endif

// [design/vector_src_map.v]
// Maps request lines to hardware interrupt numbers 4 to 31
`timescale 1ns/1ps
module vector_src_map (
    input  wire [27:0] req_in,
    input  wire [83:0] lvl_in,
    output wire [31:0] req_out,
    output wire [95:0] lvl_out
);
    // Slots 0 to 3 carry no hardware source
    assign req_out[3:0] = 4'h0;
    assign lvl_out[11:0] = 12'h000;
    genvar g;
    generate
        for (g = 4; g < 32; g = g + 1) begin : g_slot
            assign req_out[g] = req_in[g-4];
            assign lvl_out[g*3 +: 3] = lvl_in[(g-4)*3 +: 3];
        end
    endgenerate
endmodule // vector_src_map

// [verif/fetch_sequencer_model.sv]
// Sequencer model: consumes each vector after a set wait
`timescale 1ns/1ps
module fetch_sequencer_model (
    input  wire       clk,
    input  wire       rstn,
    input  wire [3:0] dly,
    input  wire       vec_valid,
    output logic      fetch_done
);
    logic [3:0] cnt_r;
    always @(posedge clk) begin
        if (!rstn) begin
            cnt_r <= 4'h0;
            fetch_done <= 1'b0;
        end else begin
            fetch_done <= 1'b0;
            // One pulse per vector; valid is still high one edge later
            if (vec_valid && !fetch_done) begin
                cnt_r <= (cnt_r >= dly) ? 4'h0 : cnt_r + 4'h1;
                fetch_done <= (cnt_r >= dly);
            end
        end
    end
endmodule // fetch_sequencer_model

// [verif/relocatable_vector_table_assertions.sv]
// Checker for the vector address outputs
`timescale 1ns/1ps
module relocatable_vector_table_assertions (
    input wire        MCLK,
    input wire        RESETN,
    input wire        CE,
    input wire [19:0] VECTOR_BASE,
    input wire        GLOBAL_EN,
    input wire        SW_REQ,
    input wire        FETCH_DONE,
    input wire        IRQ_PENDING,
    input wire        VEC_VALID,
    input wire [5:0]  VEC_NUM,
    input wire [19:0] VEC_ADDR,
    input wire        VEC_MASKABLE,
    input wire [4:0]  SEQ_CYCLES
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    a_fetch_addr: assert property (VEC_VALID |->
        VEC_ADDR == VECTOR_BASE + {VEC_NUM, 2'h0}) else $error("bad addr");
    a_area_span: assert property (VEC_VALID |->
        20'(VEC_ADDR - VECTOR_BASE) < 20'h100) else $error("out of area");
    a_seq_parity: assert property (VEC_VALID |->
        SEQ_CYCLES == (VECTOR_BASE[0] ? 5'h14 : 5'h12)) else $error("cyc");
    a_accept_next: assert property (CE && !VEC_VALID &&
        (SW_REQ || IRQ_PENDING) |=> VEC_VALID) else $error("not taken");
    a_vec_hold: assert property (VEC_VALID && !FETCH_DONE |=>
        VEC_VALID && $stable(VEC_NUM)) else $error("vector moved");
    a_fetch_release: assert property (VEC_VALID && FETCH_DONE && CE
        |=> !VEC_VALID) else $error("valid stuck");
    a_unmask_sw: assert property (VEC_VALID &&
        (VEC_NUM == 6'h00 || VEC_NUM[5]) |-> !VEC_MASKABLE) else $error("m");
    a_global_gate: assert property (!GLOBAL_EN |-> !IRQ_PENDING)
        else $error("pending while disabled");
    cover property (VEC_VALID && VEC_NUM[5]);
    cover property (VEC_VALID && SEQ_CYCLES == 5'h14);
    cover property (VEC_VALID && VEC_NUM == 6'h0A);
endmodule // relocatable_vector_table_assertions
bind relocatable_vector_table relocatable_vector_table_assertions i_chk (
    .MCLK(MCLK), .RESETN(RESETN), .CE(CE), .VECTOR_BASE(VECTOR_BASE),
    .GLOBAL_EN(GLOBAL_EN), .SW_REQ(SW_REQ), .FETCH_DONE(FETCH_DONE),
    .IRQ_PENDING(IRQ_PENDING), .VEC_VALID(VEC_VALID), .VEC_NUM(VEC_NUM),
    .VEC_ADDR(VEC_ADDR), .VEC_MASKABLE(VEC_MASKABLE), .SEQ_CYCLES(SEQ_CYCLES));

// [verif/relocatable_vector_table_tb.sv]
// Testbench for the relocatable vector address logic
`timescale 1ns/1ps
module relocatable_vector_table_tb;
    logic MCLK = 1'b0;
    logic rn, ce, wr, md, ge, sw;
    logic [19:0] bs;
    logic [7:0] wd;
    logic [2:0] pl;
    logic [34:0] rq;
    logic [83:0] lv;
    logic [5:0] sn;
    logic [3:0] dl;
    wire fd, pd, vv, vm;
    wire [2:0] vl;
    wire [4:0] sc;
    wire [5:0] vn;
    wire [19:0] va;
    wire [7:0] c1, c2;
    int n_fail = 0, total_checks = 0, cyc = 0;
    int nt [0:19] = '{4,5,6,6,7,7,8,8,9,9,10,10,11,12,13,14,15,16,15,16};
    // Two-wire/line/pin alternates, and the sources that share a slot
    logic [34:0] alt = 35'h00C0AA8, shr = 35'h00F0FFC;
    always #25 MCLK = ~MCLK;
    relocatable_vector_table i_dut (.MCLK(MCLK), .RESETN(rn), .CE(ce),
    .VECTOR_BASE(bs), .CAUSE_WR(wr), .CAUSE_WDATA(wd), .CAUSE2_WR(wr),
    .CAUSE2_WDATA(wd), .TWO_WIRE_MODE(md), .GLOBAL_EN(ge), .PROC_LEVEL(pl),
    .EXT_PIN_IRQ3_REQ(rq[0]), .CC0_REQ(rq[1]), .CC1_REQ(rq[2]), .IIC_REQ(rq[3]),
    .CCB_REQ(rq[4]), .LINE_REQ(rq[5]), .SP4_REQ(rq[6]), .EXT_PIN_IRQ5_REQ(rq[7]),
    .SP3_REQ(rq[8]), .EXT_PIN_IRQ4_REQ(rq[9]), .U2_COLL_REQ(rq[10]),
    .U2_STSP_REQ(rq[11]), .DMA0_REQ(rq[12]), .DMA1_REQ(rq[13]),
    .KEY_REQ(rq[14]), .AD_REQ(rq[15]), .U2_TX_REQ(rq[16]), .U2_RX_REQ(rq[17]),
    .U2_NACK_REQ(rq[18]), .U2_ACK_REQ(rq[19]), .UART01_REQ(rq[23:20]),
    .TMR_A_REQ(rq[28:24]), .TMR_B_REQ(rq[31:29]), .INT012_REQ(rq[34:32]),
    .SLOT_LEVELS(lv), .SW_REQ(sw), .SW_NUM(sn), .FETCH_DONE(fd),
    .IRQ_PENDING(pd), .VEC_VALID(vv), .VEC_NUM(vn), .VEC_ADDR(va),
    .VEC_LEVEL(vl), .VEC_MASKABLE(vm), .SEQ_CYCLES(sc), .CAUSE_SEL(c1),
    .CAUSE_SEL_TWO(c2));
    fetch_sequencer_model i_seq (.clk(MCLK), .rstn(rn), .dly(dl),
        .vec_valid(vv), .fetch_done(fd));
    task automatic chk(input logic [19:0] g, input logic [19:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            summarize;
        end
    end
    task automatic setsel(input logic a);
        @(negedge MCLK);
        {wr, wd, md} = {1'b1, a, a, 6'h00, a};
        @(negedge MCLK);
        wr = 1'b0;
        chk(c1 ^ c2, 20'h0);
        chk(c1, {a, a, 6'h00});
    endtask
    task automatic take(input logic [5:0] n);
        for (int i = 0; i < 20 && vv !== 1'b1; i++) @(negedge MCLK);
        chk(vm, !sw);
        {rq, sw} = '0;
        chk(vn, n);
        chk(va, bs + {n, 2'h0});
        chk(sc, bs[0] ? 20'h14 : 20'h12);
        for (int i = 0; i < 40 && vv !== 1'b0; i++) @(negedge MCLK);
        @(negedge MCLK);
    endtask
    initial begin
        {rn, ce, wr, wd, md, ge, sw, sn, pl, rq, dl} = '0;
        bs = 20'h0C400;
        lv = {28{3'h1}};
        repeat (20) @(negedge MCLK);
        {rn, ce, ge} = 3'h7;
        for (int k = 0; k < 35; k++) begin
            setsel(alt[k]);
            rq[k] = 1'b1;
            take(6'(k < 20 ? nt[k] : k - 3));
            if (shr[k]) begin
                setsel(!alt[k]);
                rq[k] = 1'b1;
                @(negedge MCLK);
                chk({pd, vv}, 20'h0);
                rq[k] = 1'b0;
            end
            dl = ~dl; // Swap prompt and slow fetch
        end
        lv[2:0] = 3'h2;
        lv[23:21] = 3'h5;
        rq[12] = 1'b1;
        rq[0] = 1'b1;
        take(6'h0B);
        chk(vl, 20'h5);
        pl = 3'h2;
        rq[0] = 1'b1;
        @(negedge MCLK);
        chk({pd, vv}, 20'h0);
        {ge, pl, bs} = {4'h0, 20'h0C401};
        @(negedge MCLK);
        chk({pd, vv}, 20'h0);
        sw = 1'b1;
        take(6'h00);
        {sw, sn} = 7'h7F;
        take(6'h3F);
        summarize;
    end
endmodule // relocatable_vector_table_tb
